/* gvc_pkg.sv */
package gvc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] REG_TIME_ALARM   = 8'h02;
  localparam logic [7:0] REG_CAP_ALARM    = 8'h04;
  localparam logic [7:0] REG_MISC_OPTS    = 8'h08;
  localparam logic [7:0] REG_OT_LEVEL     = 8'h09;
  localparam logic [7:0] REG_CYCLE_INIT   = 8'h0e;
  localparam logic [7:0] REG_CELL_LIMITS  = 8'h4a;
  localparam logic [7:0] REG_CTRL_MODE    = 8'h51;
  localparam logic [7:0] REG_ADC_OFFSET   = 8'h62;
  localparam logic [7:0] REG_CAL2         = 8'h63;
  localparam logic [7:0] REG_CAL3         = 8'h64;
  localparam logic [7:0] REG_CAL4         = 8'h65;
  localparam logic [7:0] REG_VGAIN        = 8'h66;
  localparam logic [7:0] REG_PACK_V       = 8'h70;
  localparam logic [7:0] REG_CELL1_V      = 8'h71;
  localparam logic [7:0] REG_CELL2_V      = 8'h72;
  localparam logic [7:0] REG_CELL3_V      = 8'h73;
  localparam logic [7:0] REG_CELL4_V      = 8'h74;
  localparam logic [7:0] REG_STATUS       = 8'h75;
  localparam logic [7:0] REG_UV_MV        = 8'h76;
  localparam logic [7:0] REG_OV_MV        = 8'h77;
  localparam logic [7:0] REG_OT_THRESH    = 8'h78;

  // ==========================================================================
  // Field positions
  localparam int MISC_MID_EDV_DIS  = 7;
  localparam int MISC_OT_ONLY      = 6;
  localparam int MISC_HIGH_TEMP    = 5;
  localparam int CTRL_FILT_BYPASS  = 7;
  localparam int CTRL_HOST_PEC     = 5;
  localparam int CTRL_CHG_PEC      = 4;
  localparam int CTRL_FOUR_LED     = 3;
  localparam int CTRL_SMART_CHG    = 2;
  localparam int CTRL_BCAST_SUPP   = 0;

  // ==========================================================================
  // Reset values and conversion constants
  localparam logic [15:0] VGAIN_RESET    = 16'd20000;
  localparam logic [15:0] UV_BASE_MV     = 16'd2048;
  localparam logic [15:0] OV_BASE_MV     = 16'd4096;
  localparam int          UV_STEP_SHIFT  = 6;
  localparam int          OV_STEP_SHIFT  = 5;
  localparam logic [15:0] OT_BASE_NORM   = 16'd945;
  localparam logic [15:0] OT_BASE_HIGH   = 16'd1105;
  localparam int          SCALE_SHIFT    = 15;
  localparam logic [31:0] SCALE_DIV      = 32'd1250;
  localparam int          GAIN_SHIFT     = 16;
  localparam int          CAL_SHIFT      = 3;
  localparam int          NODE_COUNT     = 4;

  // ==========================================================================
  // Cell count field settings
  localparam logic [1:0] CELLS_STACK = 2'b00;
  localparam logic [1:0] CELLS_TWO   = 2'b01;
  localparam logic [1:0] CELLS_THREE = 2'b10;
  localparam logic [1:0] CELLS_FOUR  = 2'b11;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_NODE = 2'b01,
    ST_DONE = 2'b10
  } gvc_state_e;

endpackage

/* gvc_options_volt.sv */
// Behaviour
// - Stored time and capacity alarm thresholds are reported and applied for alarms.
// - Upper nibble gives 2048+64n mV undervoltage, lower nibble 4096+32n mV overvoltage.
// - Overtemp threshold is 94.5 C, or 110.5 C in high range, minus value/10.
// - Measured temperature against overtemp threshold drives the charge FET pin.
// - Misc bit 7 set disables the middle end-of-discharge threshold.
// - Misc bit 6 set lets only safety overtemperature drive the FET pin.
// - Misc bit 5 shifts maximum and safety temperature ranges up 16 C.
// - Cycle counter starts from stored word; programmer should store zero.
// - Control bit 7 bypasses filter in discharge while both bus lines high.
// - Control bit 5 enables error-check byte on host alarm broadcasts.
// - Control bit 4 enables error-check byte on charger broadcasts.
// - Control bit 3 selects four display segments, otherwise five.
// - Control bit 2 selects learning optimised for smart charger.
// - Control bit 0 suppresses all broadcasts; mode register cannot override it.
// - Node = (reading*32768/1250 + offset) * (gain + 8*cal)/65536.
// - ADC offset is signed 8-bit, added to voltage and current readings.
// - Stack-only setting uses zero for the top cell calibration factor.
// - Pack voltage is highest node in use minus sense resistor voltage.
// - Cells are node differences, lowest against sense voltage, none beyond count.
// - Cell count 00 is stack on top input; 01/10/11 are two/three/four cells.
`timescale 1ns/1ps
module gvc_options_volt
  import gvc_pkg::*;
#(
  parameter logic [15:0] VGAIN_DEFAULT = VGAIN_RESET
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [15:0]        reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [15:0]        reg_rdata_o,
  input  wire logic [1:0]         cell_count_i,
  input  wire logic               adc_valid_i,
  input  wire logic [15:0]        cell_sense_input1_i,
  input  wire logic [15:0]        cell_sense_input2_i,
  input  wire logic [15:0]        cell_sense_input3_i,
  input  wire logic [15:0]        cell_sense_input4_i,
  input  wire logic [15:0]        sense_resistor_voltage_i,
  input  wire logic [15:0]        current_reading_i,
  output logic      [15:0]        current_offset_o,
  input  wire logic [15:0]        temperature_i,
  input  wire logic               overvoltage_i,
  input  wire logic               max_temp_i,
  input  wire logic               discharging_i,
  input  wire logic               serial_clock_pin_i,
  input  wire logic               serial_data_pin_i,
  input  wire logic               battery_mode_bcast_disable_i,
  input  wire logic [15:0]        time_to_empty_i,
  input  wire logic [15:0]        remaining_capacity_i,
  output logic                    time_alarm_o,
  output logic                    capacity_alarm_o,
  output logic      [15:0]        charge_cycle_counter_init_o,
  output logic                    charge_fet_control_pin_o,
  output logic                    mid_discharge_threshold_en_o,
  output logic                    high_temp_range_o,
  output logic                    filter_enable_o,
  output logic                    host_alarm_error_check_o,
  output logic                    charger_broadcast_error_check_o,
  output logic                    four_segment_display_o,
  output logic                    smart_charger_learning_o,
  output logic                    broadcast_enable_o,
  output logic      [15:0]        uv_limit_mv_o,
  output logic      [15:0]        ov_limit_mv_o,
  output logic      [15:0]        ot_threshold_o,
  output logic      [15:0]        pack_voltage_o,
  output logic      [15:0]        cell1_voltage_o,
  output logic      [15:0]        cell2_voltage_o,
  output logic      [15:0]        cell3_voltage_o,
  output logic      [15:0]        cell4_voltage_o,
  output logic                    voltages_valid_o
);

  // ==========================================================================
  // Configuration registers
  logic [15:0] time_alarm_q;
  logic [15:0] cap_alarm_q;
  logic [7:0]  misc_q;
  logic [7:0]  ot_level_q;
  logic [15:0] cycle_init_q;
  logic [7:0]  cell_limits_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  adc_offset_q;
  logic [7:0]  cal2_q;
  logic [7:0]  cal3_q;
  logic [7:0]  cal4_q;
  logic [15:0] vgain_q;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      time_alarm_q  <= 16'h0000;
      cap_alarm_q   <= 16'h0000;
      misc_q        <= 8'h00;
      ot_level_q    <= 8'h00;
      cycle_init_q  <= 16'h0000;
      cell_limits_q <= 8'h00;
      ctrl_q        <= 8'h00;
      adc_offset_q  <= 8'h00;
      cal2_q        <= 8'h00;
      cal3_q        <= 8'h00;
      cal4_q        <= 8'h00;
      vgain_q       <= VGAIN_DEFAULT;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        REG_TIME_ALARM:  time_alarm_q  <= reg_wdata_i;
        REG_CAP_ALARM:   cap_alarm_q   <= reg_wdata_i;
        REG_MISC_OPTS:   misc_q        <= reg_wdata_i[7:0];
        REG_OT_LEVEL:    ot_level_q    <= reg_wdata_i[7:0];
        REG_CYCLE_INIT:  cycle_init_q  <= reg_wdata_i;
        REG_CELL_LIMITS: cell_limits_q <= reg_wdata_i[7:0];
        REG_CTRL_MODE:   ctrl_q        <= reg_wdata_i[7:0];
        REG_ADC_OFFSET:  adc_offset_q  <= reg_wdata_i[7:0];
        REG_CAL2:        cal2_q        <= reg_wdata_i[7:0];
        REG_CAL3:        cal3_q        <= reg_wdata_i[7:0];
        REG_CAL4:        cal4_q        <= reg_wdata_i[7:0];
        REG_VGAIN:       vgain_q       <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      scl_sync_q <= 2'b00;
      sda_sync_q <= 2'b00;
    end else begin
      scl_sync_q <= {scl_sync_q[0], serial_clock_pin_i};
      sda_sync_q <= {sda_sync_q[0], serial_data_pin_i};
    end
  end

  // ==========================================================================
  // Option decode
  logic [15:0] ot_thresh_w;
  logic        ot_over_w;
  logic [15:0] offset_ext_w;

  // Threshold in 0.1 C units
  assign ot_thresh_w = (misc_q[MISC_HIGH_TEMP] ? OT_BASE_HIGH : OT_BASE_NORM)
                       - {8'h00, ot_level_q};
  assign ot_over_w   = temperature_i >= ot_thresh_w;
  assign offset_ext_w = {{8{adc_offset_q[7]}}, adc_offset_q};

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      charge_fet_control_pin_o        <= 1'b0;
      mid_discharge_threshold_en_o    <= 1'b1;
      high_temp_range_o               <= 1'b0;
      filter_enable_o                 <= 1'b1;
      host_alarm_error_check_o        <= 1'b0;
      charger_broadcast_error_check_o <= 1'b0;
      four_segment_display_o          <= 1'b0;
      smart_charger_learning_o        <= 1'b0;
      broadcast_enable_o              <= 1'b0;
      uv_limit_mv_o                   <= 16'h0000;
      ov_limit_mv_o                   <= 16'h0000;
      ot_threshold_o                  <= 16'h0000;
      time_alarm_o                    <= 1'b0;
      capacity_alarm_o                <= 1'b0;
      charge_cycle_counter_init_o     <= 16'h0000;
      current_offset_o                <= 16'h0000;
    end else begin
      charge_fet_control_pin_o        <= ot_over_w | (~misc_q[MISC_OT_ONLY]
                                         & (overvoltage_i | max_temp_i));
      mid_discharge_threshold_en_o    <= ~misc_q[MISC_MID_EDV_DIS];
      high_temp_range_o               <= misc_q[MISC_HIGH_TEMP];
      filter_enable_o                 <= ~(ctrl_q[CTRL_FILT_BYPASS] & discharging_i
                                         & scl_sync_q[1] & sda_sync_q[1]);
      host_alarm_error_check_o        <= ctrl_q[CTRL_HOST_PEC];
      charger_broadcast_error_check_o <= ctrl_q[CTRL_CHG_PEC];
      four_segment_display_o          <= ctrl_q[CTRL_FOUR_LED];
      smart_charger_learning_o        <= ctrl_q[CTRL_SMART_CHG];
      broadcast_enable_o              <= ~ctrl_q[CTRL_BCAST_SUPP]
                                         & ~battery_mode_bcast_disable_i;
      uv_limit_mv_o                   <= UV_BASE_MV
                                         + ({12'h000, cell_limits_q[7:4]} << UV_STEP_SHIFT);
      ov_limit_mv_o                   <= OV_BASE_MV
                                         + ({12'h000, cell_limits_q[3:0]} << OV_STEP_SHIFT);
      ot_threshold_o                  <= ot_thresh_w;
      time_alarm_o                    <= time_to_empty_i < time_alarm_q;
      capacity_alarm_o                <= remaining_capacity_i < cap_alarm_q;
      charge_cycle_counter_init_o     <= cycle_init_q;
      current_offset_o                <= current_reading_i + offset_ext_w;
    end
  end

  // ==========================================================================
  // Node voltage sequencer
  gvc_state_e         state_q;
  logic [1:0]         idx_q;
  logic [15:0]        raw_q [NODE_COUNT];
  logic [15:0]        sense_q;
  logic [1:0]         count_q;
  logic [15:0]        node_q [NODE_COUNT];
  logic [15:0]        raw_sel_w;
  logic [31:0]        scaled_w;
  logic signed [23:0] sum_w;
  logic [7:0]         cal_sel_w;
  logic signed [19:0] gain_w;
  logic signed [43:0] prod_w;

  always_comb begin
    raw_sel_w = raw_q[idx_q];
    case (idx_q)
      2'd1:    cal_sel_w = cal2_q;
      2'd2:    cal_sel_w = cal3_q;
      2'd3:    cal_sel_w = (count_q == CELLS_STACK) ? 8'h00 : cal4_q;
      default: cal_sel_w = 8'h00;
    endcase
  end

  assign scaled_w = ({16'h0000, raw_sel_w} << SCALE_SHIFT) / SCALE_DIV;
  assign sum_w    = $signed({2'b00, scaled_w[21:0]}) + $signed({{8{offset_ext_w[15]}}, offset_ext_w});
  assign gain_w   = $signed({4'h0, vgain_q})
                    + $signed({{9{cal_sel_w[7]}}, cal_sel_w, 3'b000});
  assign prod_w   = sum_w * gain_w;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      idx_q   <= 2'd0;
      count_q <= CELLS_STACK;
      sense_q <= 16'h0000;
      for (int i = 0; i < NODE_COUNT; i++) begin
        raw_q[i]  <= 16'h0000;
        node_q[i] <= 16'h0000;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (adc_valid_i) begin
            raw_q[0] <= cell_sense_input1_i;
            raw_q[1] <= cell_sense_input2_i;
            raw_q[2] <= cell_sense_input3_i;
            raw_q[3] <= cell_sense_input4_i;
            sense_q  <= sense_resistor_voltage_i;
            count_q  <= cell_count_i;
            idx_q    <= 2'd0;
            state_q  <= ST_NODE;
          end
        end
        ST_NODE: begin
          node_q[idx_q] <= prod_w[GAIN_SHIFT +: 16];
          idx_q         <= idx_q + 2'd1;
          if (idx_q == 2'd3) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Pack and cell results
  logic [15:0] cell_w [NODE_COUNT];
  logic [15:0] cell_q [NODE_COUNT];
  logic [2:0]  cells_used_w;
  logic [15:0] top_node_w;

  always_comb begin
    case (count_q)
      CELLS_TWO:   top_node_w = node_q[1];
      CELLS_THREE: top_node_w = node_q[2];
      default:     top_node_w = node_q[3];
    endcase
    case (count_q)
      CELLS_TWO:   cells_used_w = 3'd2;
      CELLS_THREE: cells_used_w = 3'd3;
      CELLS_FOUR:  cells_used_w = 3'd4;
      default:     cells_used_w = 3'd0;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < NODE_COUNT; g++) begin : g_cell
      logic [15:0] lower_w;
      if (g == 0) begin : g_low
        assign lower_w = sense_q;
      end else begin : g_up
        assign lower_w = node_q[g-1];
      end
      assign cell_w[g] = (3'(g) < cells_used_w) ? node_q[g] - lower_w : 16'h0000;
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          cell_q[g] <= 16'h0000;
        end else if (state_q == ST_DONE) begin
          cell_q[g] <= cell_w[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pack_voltage_o   <= 16'h0000;
      voltages_valid_o <= 1'b0;
    end else begin
      voltages_valid_o <= state_q == ST_DONE;
      if (state_q == ST_DONE) begin
        pack_voltage_o <= top_node_w - sense_q;
      end
    end
  end

  assign cell1_voltage_o = cell_q[0];
  assign cell2_voltage_o = cell_q[1];
  assign cell3_voltage_o = cell_q[2];
  assign cell4_voltage_o = cell_q[3];

  // ==========================================================================
  // Register read port
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_TIME_ALARM:  reg_rdata_o <= time_alarm_q;
        REG_CAP_ALARM:   reg_rdata_o <= cap_alarm_q;
        REG_MISC_OPTS:   reg_rdata_o <= {8'h00, misc_q};
        REG_OT_LEVEL:    reg_rdata_o <= {8'h00, ot_level_q};
        REG_CYCLE_INIT:  reg_rdata_o <= cycle_init_q;
        REG_CELL_LIMITS: reg_rdata_o <= {8'h00, cell_limits_q};
        REG_CTRL_MODE:   reg_rdata_o <= {8'h00, ctrl_q};
        REG_ADC_OFFSET:  reg_rdata_o <= {8'h00, adc_offset_q};
        REG_CAL2:        reg_rdata_o <= {8'h00, cal2_q};
        REG_CAL3:        reg_rdata_o <= {8'h00, cal3_q};
        REG_CAL4:        reg_rdata_o <= {8'h00, cal4_q};
        REG_VGAIN:       reg_rdata_o <= vgain_q;
        REG_PACK_V:      reg_rdata_o <= pack_voltage_o;
        REG_CELL1_V:     reg_rdata_o <= cell_q[0];
        REG_CELL2_V:     reg_rdata_o <= cell_q[1];
        REG_CELL3_V:     reg_rdata_o <= cell_q[2];
        REG_CELL4_V:     reg_rdata_o <= cell_q[3];
        REG_STATUS:      reg_rdata_o <= {13'h0000, state_q != ST_IDLE, broadcast_enable_o,
                                         charge_fet_control_pin_o};
        REG_UV_MV:       reg_rdata_o <= uv_limit_mv_o;
        REG_OV_MV:       reg_rdata_o <= ov_limit_mv_o;
        REG_OT_THRESH:   reg_rdata_o <= ot_threshold_o;
        default:         reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule

/* gvc_options_volt_monitor.sv */
`timescale 1ns/1ps
// ==========================================================================
// Port checker
module gvc_options_volt_chk
  import gvc_pkg::*;
#(
  parameter logic [15:0] VGAIN_DEFAULT = VGAIN_RESET
) (
  input wire logic        sys_clk_i, rst_n_i, reg_wr_i, adc_valid_i, overvoltage_i, max_temp_i,
  input wire logic        discharging_i, battery_mode_bcast_disable_i, voltages_valid_o,
  input wire logic        high_temp_range_o, charge_fet_control_pin_o, filter_enable_o, broadcast_enable_o,
  input wire logic [1:0]  cell_count_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i, temperature_i, pack_voltage_o, cell1_voltage_o,
  input wire logic [15:0] cell3_voltage_o, cell4_voltage_o, uv_limit_mv_o, ov_limit_mv_o, ot_threshold_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_lim;
    (reg_wr_i && reg_addr_i == REG_CELL_LIMITS) |-> ##2
      (uv_limit_mv_o == UV_BASE_MV + {6'h00, $past(reg_wdata_i[7:4], 2), 6'h00}) &&
      (ov_limit_mv_o == OV_BASE_MV + {7'h00, $past(reg_wdata_i[3:0], 2), 5'h00});
  endproperty
  a_lim: assert property (p_lim) else $error("cell limit decode wrong");
  property p_ot_thr;
    (reg_wr_i && reg_addr_i == REG_OT_LEVEL) |-> ##2 ot_threshold_o ==
      (high_temp_range_o ? OT_BASE_HIGH : OT_BASE_NORM) - {8'h00, $past(reg_wdata_i[7:0], 2)};
  endproperty
  a_ot_thr: assert property (p_ot_thr) else $error("overtemp threshold wrong");
  property p_fet_off;
    (!overvoltage_i && !max_temp_i && temperature_i < 16'h0258) [*3] |-> !charge_fet_control_pin_o;
  endproperty
  a_fet_off: assert property (p_fet_off) else $error("fet pin set without fault");
  property p_fet_hot;
    (temperature_i > 16'h0451) [*3] |-> charge_fet_control_pin_o;
  endproperty
  a_fet_hot: assert property (p_fet_hot) else $error("fet pin clear when hot");
  property p_filt;
    (!discharging_i) [*2] |-> filter_enable_o;
  endproperty
  a_filt: assert property (p_filt) else $error("filter off outside discharge");
  property p_bcast;
    battery_mode_bcast_disable_i |=> !broadcast_enable_o;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast enabled while disabled");
  property p_conv;
    voltages_valid_o |-> $past(adc_valid_i, 6);
  endproperty
  a_conv: assert property (p_conv) else $error("result without conversion");
  property p_pulse;
    voltages_valid_o |=> !voltages_valid_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid longer than one cycle");
  property p_hold;
    (!voltages_valid_o && $past(rst_n_i)) |-> $stable(pack_voltage_o) && $stable(cell1_voltage_o);
  endproperty
  a_hold: assert property (p_hold) else $error("results moved between conversions");
  property p_cells;
    (voltages_valid_o && $past(cell_count_i, 6) == CELLS_TWO) |-> cell3_voltage_o == 16'h0000 &&
      cell4_voltage_o == 16'h0000;
  endproperty
  a_cells: assert property (p_cells) else $error("cell beyond count reported");
endmodule

bind gvc_options_volt gvc_options_volt_chk #(.VGAIN_DEFAULT(VGAIN_DEFAULT)) i_gvc_options_volt_chk (.*);

/* gvc_host_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// Host and charger bus lines
module gvc_host_model (
  input  wire logic sys_clk_i,
  input  wire logic busy_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic tog_q = 1'b0;
  always_ff @(posedge sys_clk_i) begin
    tog_q <= busy_i ? ~tog_q : 1'b0;
  end
  // Pull-ups hold both lines high while idle
  assign scl_o = busy_i ? tog_q : 1'b1;
  assign sda_o = ~busy_i;
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import gvc_pkg::*;
;
  typedef struct {logic [7:0] misc, ctrl, lim, otl; logic [6:0] flg; logic [15:0] uv, ov, th;} gvc_row_s;
  // Flags: mid_en, high_temp, host_pec, chg_pec, four_led, smart, bcast_en
  gvc_row_s rows [3] = '{
    '{8'h00, 8'h00, 8'h00, 8'h00, 7'h41, 16'h0800, 16'h1000, 16'h03b1},
    '{8'ha0, 8'h3c, 8'h21, 8'h0a, 7'h3f, 16'h0880, 16'h1020, 16'h0447},
    '{8'h40, 8'h01, 8'hff, 8'hff, 7'h40, 16'h0bc0, 16'h11e0, 16'h02b2}};
  logic sys_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, adc_valid_i = 0, overvoltage_i = 0;
  logic max_temp_i = 0, discharging_i = 0, battery_mode_bcast_disable_i = 0, bus_busy = 0;
  logic [1:0] cell_count_i = 0;
  logic [7:0] reg_addr_i = 0, off = 8'hfc, c2 = 8'h08, c3 = 8'hf8, c4 = 8'h10;
  logic [15:0] reg_wdata_i = 0, cell_sense_input1_i = 16'h0271, cell_sense_input2_i = 16'h04e2;
  logic [15:0] cell_sense_input3_i = 16'h0753, cell_sense_input4_i = 16'h09c4, sense_resistor_voltage_i = 16'h0064;
  logic [15:0] current_reading_i = 16'h03e8, temperature_i = 0, time_to_empty_i = 0, remaining_capacity_i = 0;
  logic [15:0] reg_rdata_o, current_offset_o, charge_cycle_counter_init_o, uv_limit_mv_o, ov_limit_mv_o;
  logic [15:0] ot_threshold_o, pack_voltage_o, cell1_voltage_o, cell2_voltage_o, cell3_voltage_o, cell4_voltage_o;
  logic time_alarm_o, capacity_alarm_o, charge_fet_control_pin_o, mid_discharge_threshold_en_o, high_temp_range_o;
  logic filter_enable_o, host_alarm_error_check_o, charger_broadcast_error_check_o, four_segment_display_o;
  logic smart_charger_learning_o, broadcast_enable_o, voltages_valid_o, serial_clock_pin_i, serial_data_pin_i;
  int fails = 0, checks_done = 0;

  gvc_options_volt i_gvc_options_volt (.*);
  gvc_host_model i_gvc_host_model (.sys_clk_i(sys_clk_i), .busy_i(bus_busy), .scl_o(serial_clock_pin_i),
                                   .sda_o(serial_data_pin_i));

  always #5 sys_clk_i = ~sys_clk_i;

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask
  function automatic logic [15:0] nf(input logic [15:0] raw, input logic [7:0] o, input logic [7:0] c);
    longint t;
    t = ((longint'(raw) << 15) / 1250 + longint'($signed(o))) * (longint'(VGAIN_RESET) + 8 * longint'($signed(c)));
    return t[31:16];
  endfunction
  task automatic conv(input logic [1:0] cnt, input bit dbl);
    int n;
    logic [15:0] a, b, c, d, t, v;
    v = sense_resistor_voltage_i;
    a = nf(cell_sense_input1_i, off, 8'h00);
    b = nf(cell_sense_input2_i, off, c2);
    c = nf(cell_sense_input3_i, off, c3);
    d = nf(cell_sense_input4_i, off, cnt == CELLS_STACK ? 8'h00 : c4);
    t = cnt == CELLS_TWO ? b : (cnt == CELLS_THREE ? c : d);
    n = 0;
    @(posedge sys_clk_i);
    cell_count_i <= cnt;
    adc_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    adc_valid_i <= 1'b0;
    if (dbl) begin
      @(posedge sys_clk_i);
      adc_valid_i <= 1'b1;
      @(posedge sys_clk_i);
      adc_valid_i <= 1'b0;
      n = 2;
    end
    while (n < 20 && voltages_valid_o !== 1'b1) begin
      w(1);
      n++;
    end
    // Pulse launched by the fifth edge after the take
    chk(16'(n), 16'h0005);
    chk(pack_voltage_o, t - v);
    chk(cell1_voltage_o, cnt == CELLS_STACK ? 16'h0000 : a - v);
    chk(cell2_voltage_o, cnt == CELLS_STACK ? 16'h0000 : b - a);
    chk(cell3_voltage_o, cnt[1] ? c - b : 16'h0000);
    chk(cell4_voltage_o, cnt == CELLS_FOUR ? d - c : 16'h0000);
    if (dbl) begin
      repeat (8) begin
        w(1);
        chk({15'h0000, voltages_valid_o}, 16'h0000);
      end
    end
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    w(1);
    chk({14'h0000, mid_discharge_threshold_en_o, filter_enable_o}, 16'h0003);
    rd(REG_VGAIN, VGAIN_RESET);
    rd(8'h30, 16'h0000);
    endt("reset");
    foreach (rows[i]) begin
      wr(REG_MISC_OPTS, {8'h00, rows[i].misc});
      wr(REG_CTRL_MODE, {8'h00, rows[i].ctrl});
      wr(REG_CELL_LIMITS, {8'h00, rows[i].lim});
      wr(REG_OT_LEVEL, {8'h00, rows[i].otl});
      w(2);
      chk({9'h000, mid_discharge_threshold_en_o, high_temp_range_o, host_alarm_error_check_o,
           charger_broadcast_error_check_o, four_segment_display_o, smart_charger_learning_o,
           broadcast_enable_o}, {9'h000, rows[i].flg});
      chk(uv_limit_mv_o, rows[i].uv);
      chk(ov_limit_mv_o, rows[i].ov);
      chk(ot_threshold_o, rows[i].th);
    end
    rd(REG_CELL_LIMITS, 16'h00ff);
    endt("options");
    wr(REG_OT_LEVEL, 16'h0000);
    wr(REG_MISC_OPTS, 16'h0000);
    overvoltage_i <= 1'b1;
    w(3);
    chk({15'h0000, charge_fet_control_pin_o}, 16'h0001);
    wr(REG_MISC_OPTS, 16'h0040);
    w(3);
    chk({15'h0000, charge_fet_control_pin_o}, 16'h0000);
    temperature_i <= 16'h0400;
    w(3);
    chk({15'h0000, charge_fet_control_pin_o}, 16'h0001);
    wr(REG_MISC_OPTS, 16'h0060);
    w(3);
    chk({15'h0000, charge_fet_control_pin_o}, 16'h0000);
    temperature_i <= 16'h0460;
    w(3);
    chk({15'h0000, charge_fet_control_pin_o}, 16'h0001);
    overvoltage_i <= 1'b0;
    temperature_i <= 16'h0000;
    endt("fet");
    wr(REG_CTRL_MODE, 16'h0080);
    discharging_i <= 1'b1;
    w(6);
    chk({15'h0000, filter_enable_o}, 16'h0000);
    bus_busy <= 1'b1;
    w(6);
    chk({15'h0000, filter_enable_o}, 16'h0001);
    bus_busy <= 1'b0;
    discharging_i <= 1'b0;
    wr(REG_CTRL_MODE, 16'h0000);
    battery_mode_bcast_disable_i <= 1'b1;
    w(3);
    chk({15'h0000, broadcast_enable_o}, 16'h0000);
    battery_mode_bcast_disable_i <= 1'b0;
    endt("filter and broadcast");
    wr(REG_TIME_ALARM, 16'h0064);
    wr(REG_CAP_ALARM, 16'h0064);
    wr(REG_CYCLE_INIT, 16'h0000);
    time_to_empty_i <= 16'h0063;
    remaining_capacity_i <= 16'h0064;
    w(3);
    chk({14'h0000, time_alarm_o, capacity_alarm_o}, 16'h0002);
    chk(charge_cycle_counter_init_o, 16'h0000);
    endt("alarms");
    wr(REG_ADC_OFFSET, {8'h00, off});
    wr(REG_CAL2, {8'h00, c2});
    wr(REG_CAL3, {8'h00, c3});
    wr(REG_CAL4, {8'h00, c4});
    w(3);
    chk(current_offset_o, 16'h03e4);
    for (int k = 0; k < 4; k++) begin
      conv(2'(k), 1'b0);
    end
    conv(CELLS_FOUR, 1'b1);
    endt("voltages");
    wrap_up();
  end
endmodule
